//--- logic/pcfg_pad_mux.sv
// What this block does
// (RQ1) One pad register per pin, two windows
// (RQ2) Pad registers reset to all zeros
// (RQ3) Bit 7 enables digital input buffer
// (RQ4) Bit 5 connects weak pull-up
// (RQ5) Bit 4 connects weak pull-down
// (RQ6) Bit 3 closes primary analog switch
// (RQ7) Bit 6 closes second analog switch
// (RQ8) Bit 2 enables high-side driver
// (RQ9) Bit 1 enables low-side driver
// (RQ10) Bit 0 inverts sampled input level
// (RQ11) Software forms output modes from drivers
// (RQ12) Software picks bits for classic modes
// (RQ13) Function-select registers for pins 0, 1
// (RQ14) Bit 7 routes touch channel, needs analog
// (RQ15) Pin 0 bit 6 carries I2C master data
// (RQ16) Pin 0 bit 5 carries slave2 data
// (RQ17) Pin 0 capture/compare 0 and MISO
// (RQ18) Pin 1 bits 6, 5 carry I2C clocks
// (RQ19) Pin 1 capture/compare 1 and SCK
// (RQ20) Bits 2, 1 join pin-interrupt groups
// (RQ21) Bit 0 enables plain GPIO, off at reset
// (RQ22) Fixed priority picks one output source
`timescale 1ns/1ns
module pcfg_pad_mux
  import pcfg_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset,
  // Extended register space access
  input  wire logic [15:0]         cfg_addr,
  input  wire logic                cfg_wr,
  input  wire logic                cfg_rd,
  input  wire logic [7:0]          cfg_wdata,
  output logic      [7:0]          cfg_rdata,
  // Pad pins: level seen on each pin
  input  wire logic [NUM_PINS-1:0] pad_in,
  // Pad electrical controls
  output logic      [NUM_PINS-1:0] input_buffer_on,
  output logic      [NUM_PINS-1:0] analog_switch_second,
  output logic      [NUM_PINS-1:0] pullup_on,
  output logic      [NUM_PINS-1:0] pulldown_on,
  output logic      [NUM_PINS-1:0] analog_switch_primary,
  output logic      [NUM_PINS-1:0] high_side_driver_on,
  output logic      [NUM_PINS-1:0] low_side_driver_on,
  output logic      [NUM_PINS-1:0] pad_out,
  // Conditioned pin levels to the core
  output logic      [NUM_PINS-1:0] pin_level,
  // Plain GPIO data from the port logic
  input  wire logic [NUM_PINS-1:0] gpio_data_out,
  // Peripheral drive values for pins 0 and 1
  input  wire logic                i2c_master_sda_out,
  input  wire logic                i2c_slave2_sda_out,
  input  wire logic                capcomp0_out,
  input  wire logic                spi_miso_out,
  input  wire logic                i2c_master_scl_out,
  input  wire logic                i2c_slave2_scl_out,
  input  wire logic                capcomp1_out,
  input  wire logic                spi_sck_out,
  // Peripheral receive values from pins 0 and 1
  output logic                     i2c_master_sda_in,
  output logic                     i2c_slave2_sda_in,
  output logic                     capcomp0_in,
  output logic                     spi_miso_in,
  output logic                     i2c_master_scl_in,
  output logic                     i2c_slave2_scl_in,
  output logic                     capcomp1_in,
  output logic                     spi_sck_in,
  // Touch routing and pin-interrupt group inputs
  output logic                     touch_ch0_route,
  output logic                     touch_ch1_route,
  output logic                     pin_irq_group0,
  output logic                     pin_irq_group1
);

  // Pad configuration storage, one byte per pin
  logic [7:0]          pad_cfg_q [NUM_PINS];
  // Function-select storage for pins 0 and 1
  logic [7:0]          fsel_q    [2];
  // Input synchroniser stages and accepted level
  logic [NUM_PINS-1:0] sync1_q;
  logic [NUM_PINS-1:0] sync2_q;
  logic [NUM_PINS-1:0] sync3_q;
  logic [NUM_PINS-1:0] stable_q;
  // Conditioned levels
  logic [NUM_PINS-1:0] pin_level_q;
  logic [NUM_PINS-1:0] pin_level_d;
  // Pad output data
  logic [NUM_PINS-1:0] pad_out_q;
  logic [NUM_PINS-1:0] pad_out_d;
  // Read data
  logic [7:0]          rdata_q;
  logic [7:0]          rdata_d;
  // Routed peripheral inputs and flags
  logic [7:0]          route_q;
  logic [7:0]          route_d;
  logic [3:0]          flag_q;
  logic [3:0]          flag_d;
  // Address decode of the current access
  logic [IDX_W:0]      pad_hit;
  // Sources chosen for the two muxed pins
  pcfg_src_type        src0;
  pcfg_src_type        src1;

  // Maps an address onto a pad index; top bit flags a hit
  function automatic logic [IDX_W:0] pad_decode(input logic [15:0] addr);
    // Offsets into the two pad windows
    logic [15:0] off01;
    logic [15:0] off2;
    off01 = addr - PORT0_PAD_BASE;
    off2  = addr - PORT2_PAD_BASE;
    if (addr >= PORT0_PAD_BASE && off01 < {11'h000, PORT01_PADS}) begin
      // Ports 0 and 1 share one window
      pad_decode = {1'b1, off01[IDX_W-1:0]};
    end else if (addr >= PORT2_PAD_BASE && off2 < {11'h000, PORT2_PADS}) begin
      // Port 2 pads follow the port 1 pads
      pad_decode = {1'b1, off2[IDX_W-1:0] + PORT01_PADS};
    end else begin
      // Outside both windows: no hit
      pad_decode = '0;
    end
  endfunction

  // Fixed priority over output sources of a muxed pin
  function automatic pcfg_src_type pick_source(input logic [7:0] fsel);
    // Highest priority first, plain GPIO last
    if (fsel[I2C_MASTER_ROUTE_BIT]) begin
      pick_source = SRC_I2C_M;
    end else if (fsel[I2C_SLAVE2_ROUTE_BIT]) begin
      pick_source = SRC_I2C_S2;
    end else if (fsel[CAPCOMP_ROUTE_BIT]) begin
      pick_source = SRC_CAPCOMP;
    end else if (fsel[SPI_ROUTE_BIT]) begin
      pick_source = SRC_SPI;
    end else if (fsel[PLAIN_GPIO_BIT]) begin
      pick_source = SRC_GPIO; // RQ21
    end else begin
      // Nothing enabled leaves the pad data low
      pick_source = SRC_NONE;
    end
  endfunction

  // Drive value for a chosen source
  function automatic logic source_value(input pcfg_src_type src,
                                        input logic          mst,
                                        input logic          slv,
                                        input logic          ccp,
                                        input logic          spi,
                                        input logic          gpio);
    // An empty pick drives low
    case (src)
      SRC_I2C_M:   source_value = mst;
      SRC_I2C_S2:  source_value = slv;
      SRC_CAPCOMP: source_value = ccp;
      SRC_SPI:     source_value = spi;
      SRC_GPIO:    source_value = gpio;
      default:     source_value = 1'b0;
    endcase
  endfunction

  // Address decode and output source picks
  assign pad_hit = pad_decode(cfg_addr);
  assign src0    = pick_source(fsel_q[0]);
  assign src1    = pick_source(fsel_q[1]);

  // Pad register writes
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      // Every pad back to all off
      for (int i = 0; i < NUM_PINS; i++) begin
        pad_cfg_q[i] <= PAD_CFG_RESET; // RQ2
      end
    end else if (cfg_wr && pad_hit[IDX_W]) begin
      // Decoded pad takes the byte
      pad_cfg_q[pad_hit[IDX_W-1:0]] <= cfg_wdata; // RQ1
    end
  end

  // Function-select register writes
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      // Both selectors start with every function off
      fsel_q[0] <= FSEL_RESET; // RQ13 RQ21
      fsel_q[1] <= FSEL_RESET;
    end else if (cfg_wr && cfg_addr == PIN0_FSEL_ADDR) begin
      // Pin 0 selector
      fsel_q[0] <= cfg_wdata; // RQ13
    end else if (cfg_wr && cfg_addr == PIN1_FSEL_ADDR) begin
      // Pin 1 selector
      fsel_q[1] <= cfg_wdata; // RQ13
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    // Pad window first, then the two selectors
    if (pad_hit[IDX_W]) begin
      rdata_d = pad_cfg_q[pad_hit[IDX_W-1:0]]; // RQ1
    end else if (cfg_addr == PIN0_FSEL_ADDR) begin
      rdata_d = fsel_q[0]; // RQ13
    end else if (cfg_addr == PIN1_FSEL_ADDR) begin
      rdata_d = fsel_q[1]; // RQ13
    end
  end

  // Read data register, loaded on a read strobe
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      // Nothing read yet
      rdata_q <= 8'h00;
    end else if (cfg_rd) begin
      // Value holds until the next read strobe
      rdata_q <= rdata_d;
    end
  end

  // Three-stage pin synchroniser
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      // All stages start low
      sync1_q  <= '0;
      sync2_q  <= '0;
      sync3_q  <= '0;
      stable_q <= '0;
    end else begin
      // Shift raw pin levels down the chain
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int i = 0; i < NUM_PINS; i++) begin
        // Accept a change once the last two stages agree
        if (sync2_q[i] == sync3_q[i]) begin
          stable_q[i] <= sync3_q[i];
        end
      end
    end
  end

  // Input gating by the buffer, then polarity
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pad_cfg_q[i][INPUT_BUFFER_ON_BIT]) begin // RQ3
        // Buffer on: pass the level, inverted on request
        pin_level_d[i] = stable_q[i] ^ pad_cfg_q[i][INPUT_INVERT_BIT]; // RQ10
      end else begin
        // Buffer off: core sees a steady low
        pin_level_d[i] = 1'b0; // RQ3
      end
    end
  end

  // Output data: muxed pins by priority, the rest from GPIO
  always_comb begin
    // Pins without a selector follow GPIO
    pad_out_d    = gpio_data_out;
    // Pins 0 and 1 take the priority pick
    pad_out_d[0] = source_value(src0, i2c_master_sda_out, i2c_slave2_sda_out, // RQ22
                                capcomp0_out, spi_miso_out, gpio_data_out[0]); // RQ15 RQ16 RQ17
    pad_out_d[1] = source_value(src1, i2c_master_scl_out, i2c_slave2_scl_out, // RQ22
                                capcomp1_out, spi_sck_out, gpio_data_out[1]); // RQ18 RQ19
  end

  // Peripheral input routing; idle I2C lines read high
  always_comb begin
    // Pin 0 receivers
    route_d[0] = fsel_q[0][I2C_MASTER_ROUTE_BIT] ? pin_level_q[0] : 1'b1; // RQ15
    route_d[1] = fsel_q[0][I2C_SLAVE2_ROUTE_BIT] ? pin_level_q[0] : 1'b1; // RQ16
    route_d[2] = fsel_q[0][CAPCOMP_ROUTE_BIT] & pin_level_q[0]; // RQ17
    route_d[3] = fsel_q[0][SPI_ROUTE_BIT] & pin_level_q[0]; // RQ17
    // Pin 1 receivers
    route_d[4] = fsel_q[1][I2C_MASTER_ROUTE_BIT] ? pin_level_q[1] : 1'b1; // RQ18
    route_d[5] = fsel_q[1][I2C_SLAVE2_ROUTE_BIT] ? pin_level_q[1] : 1'b1; // RQ18
    route_d[6] = fsel_q[1][CAPCOMP_ROUTE_BIT] & pin_level_q[1]; // RQ19
    route_d[7] = fsel_q[1][SPI_ROUTE_BIT] & pin_level_q[1]; // RQ19
  end

  // Touch routes and pin-interrupt group terms
  always_comb begin
    // Touch needs the primary analog switch as well
    flag_d[0] = fsel_q[0][TOUCH_ROUTE_BIT] & pad_cfg_q[0][ANALOG_SWITCH_PRIMARY_BIT]; // RQ14
    flag_d[1] = fsel_q[1][TOUCH_ROUTE_BIT] & pad_cfg_q[1][ANALOG_SWITCH_PRIMARY_BIT]; // RQ14
    // A pin may belong to both groups at once
    flag_d[2] = (fsel_q[0][IRQ_GROUP0_BIT] & pin_level_q[0]) |
                (fsel_q[1][IRQ_GROUP0_BIT] & pin_level_q[1]); // RQ20
    flag_d[3] = (fsel_q[0][IRQ_GROUP1_BIT] & pin_level_q[0]) |
                (fsel_q[1][IRQ_GROUP1_BIT] & pin_level_q[1]); // RQ20
  end

  // Registered levels, pad data and routed signals
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      // Idle values: I2C receive lines high, the rest low
      pin_level_q <= '0;
      pad_out_q   <= '0;
      route_q     <= ROUTE_RESET;
      flag_q      <= 4'h0;
    end else begin
      // Everything follows its next value one cycle later
      pin_level_q <= pin_level_d;
      pad_out_q   <= pad_out_d;
      route_q     <= route_d;
      flag_q      <= flag_d;
    end
  end

  // Pad control bits straight from the registers
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      // One control bit per pad function
      input_buffer_on[i]       = pad_cfg_q[i][INPUT_BUFFER_ON_BIT]; // RQ3
      analog_switch_second[i]  = pad_cfg_q[i][ANALOG_SWITCH_SECOND_BIT]; // RQ7
      pullup_on[i]             = pad_cfg_q[i][PULLUP_ON_BIT]; // RQ4
      pulldown_on[i]           = pad_cfg_q[i][PULLDOWN_ON_BIT]; // RQ5
      analog_switch_primary[i] = pad_cfg_q[i][ANALOG_SWITCH_PRIMARY_BIT]; // RQ6
      high_side_driver_on[i]   = pad_cfg_q[i][HIGH_SIDE_DRIVER_ON_BIT]; // RQ8
      low_side_driver_on[i]    = pad_cfg_q[i][LOW_SIDE_DRIVER_ON_BIT]; // RQ9
    end
  end

  // Remaining outputs
  assign cfg_rdata          = rdata_q;
  assign pin_level          = pin_level_q;
  assign pad_out            = pad_out_q;
  // Receive lines for pins 0 and 1
  assign i2c_master_sda_in  = route_q[0];
  assign i2c_slave2_sda_in  = route_q[1];
  assign capcomp0_in        = route_q[2];
  assign spi_miso_in        = route_q[3];
  assign i2c_master_scl_in  = route_q[4];
  assign i2c_slave2_scl_in  = route_q[5];
  assign capcomp1_in        = route_q[6];
  assign spi_sck_in         = route_q[7];
  // Touch routes and interrupt groups
  assign touch_ch0_route    = flag_q[0];
  assign touch_ch1_route    = flag_q[1];
  assign pin_irq_group0     = flag_q[2];
  assign pin_irq_group1     = flag_q[3];

endmodule

//--- logic/pcfg_pkg.sv
package pcfg_pkg;
  // Pin counts
  localparam int unsigned NUM_PINS     = 20;
  localparam int unsigned IDX_W        = 5;
  // Pad configuration windows in extended register space
  localparam logic [15:0] PORT0_PAD_BASE = 16'hA040;
  localparam logic [15:0] PORT1_PAD_BASE = 16'hA048;
  localparam logic [15:0] PORT2_PAD_BASE = 16'hA060;
  localparam logic [4:0]  PORT01_PADS    = 5'h10;
  localparam logic [4:0]  PORT2_PADS     = 5'h04;
  // Function-select registers for port 0 pins 0 and 1
  localparam logic [15:0] PIN0_FSEL_ADDR = 16'hA050;
  localparam logic [15:0] PIN1_FSEL_ADDR = 16'hA051;
  // Values after reset
  localparam logic [7:0]  PAD_CFG_RESET  = 8'h00;
  localparam logic [7:0]  FSEL_RESET     = 8'h00;
  localparam logic [7:0]  ROUTE_RESET    = 8'h33;  // I2C receive lines idle high
  // Pad configuration field positions
  localparam int unsigned INPUT_BUFFER_ON_BIT     = 7;
  localparam int unsigned ANALOG_SWITCH_SECOND_BIT = 6;
  localparam int unsigned PULLUP_ON_BIT           = 5;
  localparam int unsigned PULLDOWN_ON_BIT         = 4;
  localparam int unsigned ANALOG_SWITCH_PRIMARY_BIT = 3;
  localparam int unsigned HIGH_SIDE_DRIVER_ON_BIT = 2;
  localparam int unsigned LOW_SIDE_DRIVER_ON_BIT  = 1;
  localparam int unsigned INPUT_INVERT_BIT        = 0;
  // Function-select field positions
  localparam int unsigned TOUCH_ROUTE_BIT      = 7;
  localparam int unsigned I2C_MASTER_ROUTE_BIT = 6;
  localparam int unsigned I2C_SLAVE2_ROUTE_BIT = 5;
  localparam int unsigned CAPCOMP_ROUTE_BIT    = 4;
  localparam int unsigned SPI_ROUTE_BIT        = 3;
  localparam int unsigned IRQ_GROUP1_BIT       = 2;
  localparam int unsigned IRQ_GROUP0_BIT       = 1;
  localparam int unsigned PLAIN_GPIO_BIT       = 0;
  // Output source chosen for a muxed pin
  typedef enum logic [2:0] {
    SRC_NONE     = 3'h0,
    SRC_I2C_M    = 3'h1,
    SRC_I2C_S2   = 3'h2,
    SRC_CAPCOMP  = 3'h3,
    SRC_SPI      = 3'h4,
    SRC_GPIO     = 3'h5
  } pcfg_src_type;
endpackage

//--- sim/pcfg_pin_model.sv
`timescale 1ns/1ns
module pcfg_pin_model
  import pcfg_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset,
  // Pad controls from the block
  input  wire logic [NUM_PINS-1:0] pad_out,
  input  wire logic [NUM_PINS-1:0] high_side_driver_on,
  input  wire logic [NUM_PINS-1:0] low_side_driver_on,
  input  wire logic [NUM_PINS-1:0] pullup_on,
  input  wire logic [NUM_PINS-1:0] pulldown_on,
  // Outside drive on each pin
  input  wire logic [NUM_PINS-1:0] ext_en,
  input  wire logic [NUM_PINS-1:0] ext_val,
  // Resolved pin level
  output logic      [NUM_PINS-1:0] pad_in
);
  logic tgl_q;  // Floating pins wander every cycle

  // Noise source for undriven pins
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tgl_q <= 1'b0;
    end else begin
      tgl_q <= ~tgl_q;
    end
  end

  // Strong drivers, then outside drive, then weak pulls
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      if (high_side_driver_on[p] && pad_out[p]) begin
        pad_in[p] = 1'b1;
      end else if (low_side_driver_on[p] && !pad_out[p]) begin
        pad_in[p] = 1'b0;
      end else if (ext_en[p]) begin
        pad_in[p] = ext_val[p];
      end else if (pullup_on[p]) begin
        pad_in[p] = 1'b1;
      end else if (pulldown_on[p]) begin
        pad_in[p] = 1'b0;
      end else begin
        pad_in[p] = tgl_q;
      end
    end
  end
endmodule

//--- sim/pcfg_pad_mux_props.sv
`timescale 1ns/1ns
module pcfg_pad_mux_props
  import pcfg_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset,
  // Register access
  input  wire logic [15:0]         cfg_addr,
  input  wire logic                cfg_wr,
  input  wire logic                cfg_rd,
  input  wire logic [7:0]          cfg_wdata,
  input  wire logic [7:0]          cfg_rdata,
  // Pad side
  input  wire logic [NUM_PINS-1:0] input_buffer_on,
  input  wire logic [NUM_PINS-1:0] pullup_on,
  input  wire logic [NUM_PINS-1:0] pulldown_on,
  input  wire logic [NUM_PINS-1:0] analog_switch_primary,
  input  wire logic [NUM_PINS-1:0] high_side_driver_on,
  input  wire logic [NUM_PINS-1:0] low_side_driver_on,
  input  wire logic [NUM_PINS-1:0] pin_level,
  input  wire logic                touch_ch0_route,
  input  wire logic                pin_irq_group0
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Writes to single pad registers
  sequence pad0_wr; cfg_wr && cfg_addr == 16'hA040; endsequence
  sequence pad8_wr; cfg_wr && cfg_addr == 16'hA048; endsequence
  sequence pad19_wr; cfg_wr && cfg_addr == 16'hA063; endsequence
  pad0_bits_a: assert property (pad0_wr |=>
    input_buffer_on[0] == $past(cfg_wdata[7]) && high_side_driver_on[0] == $past(cfg_wdata[2])
    && low_side_driver_on[0] == $past(cfg_wdata[1])) else $error("pad 0 bits wrong");
  port1_pull_a: assert property (pad8_wr |=> pullup_on[8] == $past(cfg_wdata[5]))
    else $error("pad 8 pull-up wrong");
  port2_bits_a: assert property (pad19_wr |=> pulldown_on[19] == $past(cfg_wdata[4])
    && analog_switch_primary[19] == $past(cfg_wdata[3])) else $error("pad 19 bits wrong");
  unmapped_read_a: assert property (cfg_rd && cfg_addr == 16'hA064 |=> cfg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!cfg_rd |=> $stable(cfg_rdata))
    else $error("read data moved");
  buffer_gate_a: assert property (!input_buffer_on[2] [*2] |-> !pin_level[2])
    else $error("level seen with buffer off");
  touch_gate_a: assert property (!analog_switch_primary[0] [*2] |-> !touch_ch0_route)
    else $error("touch routed without analog switch");
  irq_idle_a: assert property ((!pin_level[0] && !pin_level[1]) [*2] |-> !pin_irq_group0)
    else $error("group 0 high with member pins low");
endmodule

bind pcfg_pad_mux pcfg_pad_mux_props i_pcfg_pad_mux_props (.sys_clk, .reset, .cfg_addr,
  .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata, .input_buffer_on, .pullup_on, .pulldown_on,
  .analog_switch_primary, .high_side_driver_on, .low_side_driver_on, .pin_level,
  .touch_ch0_route, .pin_irq_group0);

//--- sim/pad_config_and_function_select_tb_top.sv
`timescale 1ns/1ns
module pad_config_and_function_select_tb_top
  import pcfg_pkg::*;
();
  logic                sys_clk = 1'b0;
  logic                reset, cfg_wr, cfg_rd;
  logic [15:0]         cfg_addr;
  logic [7:0]          cfg_wdata, cfg_rdata, v, r;
  logic [4:0]          w;
  logic [3:0]          src;  // Peripheral drive values, shared by pins 0 and 1
  logic [NUM_PINS-1:0] pad_in, input_buffer_on, analog_switch_second, pullup_on, pulldown_on;
  logic [NUM_PINS-1:0] analog_switch_primary, high_side_driver_on, low_side_driver_on;
  logic [NUM_PINS-1:0] pad_out, pin_level, gpio_data_out, ext_en, ext_val;
  logic                i2c_master_sda_in, i2c_slave2_sda_in, capcomp0_in, spi_miso_in;
  logic                i2c_master_scl_in, i2c_slave2_scl_in, capcomp1_in, spi_sck_in;
  logic                touch_ch0_route, touch_ch1_route, pin_irq_group0, pin_irq_group1;
  logic [7:0]          cf [3] = '{8'h86, 8'hA2, 8'h94};  // Push-pull, sink+up, source+down
  int                  sh [5] = '{0, 1, 2, 3, 6};  // Narrows select to one source down
  int                  error_cnt, comparisons;

  always #2 sys_clk = ~sys_clk;

  pcfg_pad_mux i_pcfg_pad_mux (.sys_clk, .reset, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata,
    .cfg_rdata, .pad_in, .input_buffer_on, .analog_switch_second, .pullup_on, .pulldown_on,
    .analog_switch_primary, .high_side_driver_on, .low_side_driver_on, .pad_out, .pin_level,
    .gpio_data_out, .i2c_master_sda_out(src[3]), .i2c_slave2_sda_out(src[2]),
    .capcomp0_out(src[1]), .spi_miso_out(src[0]), .i2c_master_scl_out(src[3]),
    .i2c_slave2_scl_out(src[2]), .capcomp1_out(src[1]), .spi_sck_out(src[0]),
    .i2c_master_sda_in, .i2c_slave2_sda_in, .capcomp0_in, .spi_miso_in,
    .i2c_master_scl_in, .i2c_slave2_scl_in, .capcomp1_in, .spi_sck_in,
    .touch_ch0_route, .touch_ch1_route, .pin_irq_group0, .pin_irq_group1);

  pcfg_pin_model i_pcfg_pin_model (.sys_clk, .reset, .pad_out, .high_side_driver_on,
    .low_side_driver_on, .pullup_on, .pulldown_on, .ext_en, .ext_val, .pad_in);

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    d = cfg_rdata;
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Pad register address of a pin
  function automatic logic [15:0] pa(input int p);
    return (p < 16) ? 16'hA040 + 16'(p) : 16'hA050 + 16'(p);
  endfunction

  // Reset, then every register must read zero
  task automatic rst_chk;
    @(negedge sys_clk);
    reset = 1'b1;
    wt(3);
    reset = 1'b0;
    for (int p = 0; p < NUM_PINS; p++) begin
      rd(pa(p), r);
      chk(r, 8'h00);
    end
    rd(16'hA050, r);
    chk(r, 8'h00);
    rd(16'hA051, r);
    chk(r, 8'h00);
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog well past the expected run length
  initial begin
    #20000;
    error_cnt++;
    close_out;
  end

  initial begin
    {reset, cfg_wr, cfg_rd} = 3'b100;
    {cfg_addr, cfg_wdata, src} = '0;
    {gpio_data_out, ext_en, ext_val} = '0;
    error_cnt = 0;
    comparisons = 0;
    rst_chk;
    $display("test reset_values done");
    for (int p = 0; p < NUM_PINS; p++) begin
      v = 8'h5A ^ (8'(p) * 8'h0B);
      wr(pa(p), v);
      rd(pa(p), r);
      chk(r, v);
      chk({input_buffer_on[p], analog_switch_second[p], pullup_on[p], pulldown_on[p],
        analog_switch_primary[p], high_side_driver_on[p], low_side_driver_on[p], 1'b0},
        v & 8'hFE);
    end
    wr(16'hA050, 8'hC3);
    rd(16'hA050, r);
    chk(r, 8'hC3);
    wr(16'hA051, 8'h3C);
    rd(16'hA051, r);
    chk(r, 8'h3C);
    wr(16'hA064, 8'hFF);
    rd(16'hA064, r);
    chk(r, 8'h00);
    rd(16'hA052, r);
    chk(r, 8'h00);
    $display("test register_map done");
    rst_chk;
    $display("test second_reset done");
    ext_en[2] = 1'b1;
    ext_val[2] = 1'b1;
    wr(pa(2), 8'h80);
    wt(8);
    chk(pin_level[2], 1'b1);
    wr(pa(2), 8'h81);
    wt(8);
    chk(pin_level[2], 1'b0);
    ext_val[2] = 1'b0;
    wr(pa(2), 8'h01);
    wt(8);
    chk(pin_level[2], 1'b0);
    for (int m = 0; m < 6; m++) begin
      gpio_data_out[4] = m[0];
      wr(pa(4), cf[m / 2]);
      wt(8);
      chk(pin_level[4], m[0]);
    end
    $display("test pad_paths done");
    for (int k = 0; k < 5; k++) begin
      for (int e = 0; e < 2; e++) begin
        w = 5'h10 >> k;
        w = e[0] ? w : ~w;
        src = w[4:1];
        gpio_data_out[1:0] = {2{w[0]}};
        wr(16'hA050, 8'h7F >> sh[k]);
        wr(16'hA051, 8'h7F >> sh[k]);
        wt(2);
        chk(pad_out[1:0], {2{e[0]}});
      end
    end
    wr(16'hA050, 8'h00);
    wr(16'hA051, 8'h00);
    src = 4'hF;
    gpio_data_out[1:0] = 2'b11;
    wt(2);
    chk(pad_out[1:0], 2'b00);
    $display("test function_priority done");
    ext_en[0] = 1'b1;
    ext_val[0] = 1'b1;
    wr(pa(0), 8'h88);
    wr(16'hA050, 8'hB6);
    wt(8);
    chk({capcomp0_in, spi_miso_in, i2c_master_sda_in, i2c_slave2_sda_in, touch_ch0_route,
      pin_irq_group0, pin_irq_group1}, 8'h5F);
    ext_val[0] = 1'b0;
    wr(pa(0), 8'h80);
    wt(8);
    chk({touch_ch0_route, pin_irq_group0, capcomp0_in, i2c_slave2_sda_in}, 8'h00);
    ext_en[1] = 1'b1;
    ext_val[1] = 1'b0;
    wr(pa(1), 8'h88);
    wr(16'hA051, 8'hFC);
    wt(8);
    chk({i2c_master_scl_in, i2c_slave2_scl_in, capcomp1_in, spi_sck_in, touch_ch1_route,
      pin_irq_group0, pin_irq_group1}, 8'h04);
    ext_val[1] = 1'b1;
    wt(8);
    chk({i2c_master_scl_in, i2c_slave2_scl_in, capcomp1_in, spi_sck_in, touch_ch1_route,
      pin_irq_group0, pin_irq_group1}, 8'h7D);
    $display("test routed_inputs done");
    close_out;
  end
endmodule
